// ---- inc/aat_pkg.sv ----
// shared constants and types for the acquisition arm and trigger control
package aat_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SETUP_TIME_NS = 40;
    localparam int SETUP_CYCLES = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // register map, byte addresses
    localparam int ADDR_W = 5;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_CMD = 5'h04;
    localparam logic [4:0] REG_TRIG_CFG = 5'h08;
    localparam logic [4:0] REG_BURST_LEN = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_DROP_CNT = 5'h14;
    localparam logic [4:0] REG_FRAME_CNT = 5'h18;

    // ==========================================================
    // field positions
    localparam int CTRL_CONT_BIT = 0;
    localparam int CTRL_SEL_BIT = 1;
    localparam int CMD_ARM_BIT = 0;
    localparam int CMD_DISARM_BIT = 1;
    localparam int CMD_SWTRIG_BIT = 2;
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_ORIGIN_LSB = 1;
    localparam int CFG_FALL_BIT = 3;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_PEND_BIT = 3;
    localparam int STAT_CNT_LSB = 8;

    // ==========================================================
    // reset values and limits
    localparam logic [7:0] BURST_LEN_RST = 8'h01;
    localparam logic [7:0] BURST_LEN_MIN = 8'h01;
    localparam logic [7:0] BURST_LEN_MAX = 8'hff;
    localparam int LINE_COUNT = 2;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        AAT_ORG_SW,
        AAT_ORG_LINE1,
        AAT_ORG_LINE2,
        AAT_ORG_NONE
    } aat_origin_t;

    typedef struct packed {
        logic falling;
        aat_origin_t origin;
        logic enable;
    } aat_trig_cfg_t;

    localparam aat_trig_cfg_t TRIG_CFG_RST = '{falling: 1'b0, origin: AAT_ORG_SW, enable: 1'b0};

    typedef enum logic [2:0] {
        AAT_ST_IDLE,
        AAT_ST_SETUP,
        AAT_ST_WAIT_ARM,
        AAT_ST_WAIT_FRAME,
        AAT_ST_ACQ
    } aat_state_t;

endpackage : aat_pkg

// ---- verification/aat_acq_checker.sv ----
// port assertions for the acquisition control block
`timescale 1ns/1ps
module aat_acq_checker
    import aat_pkg::*;
#(
    parameter int SETUP_CNT = SETUP_CYCLES,
    parameter int LINES = LINE_COUNT
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // lines and frame path
    input wire logic [LINES-1:0] trig_line,
    input wire logic frame_start,
    input wire logic frame_active,
    input wire logic frame_done
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic cmd_wr;
    logic armed_q;
    logic [7:0] since_q;
    assign cmd_wr = avs_write && !avs_waitrequest && avs_address == REG_CMD && avs_byteenable[0];
    // armed from arm command until disarm command
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            armed_q <= 1'b0;
        else if (cmd_wr && avs_writedata[CMD_ARM_BIT])
            armed_q <= 1'b1;
        else if (cmd_wr && avs_writedata[CMD_DISARM_BIT])
            armed_q <= 1'b0;
    end
    // cycles since the last arm command, saturating
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            since_q <= 8'hff;
        else if (cmd_wr && avs_writedata[CMD_ARM_BIT])
            since_q <= 8'h00;
        else if (since_q != 8'hff)
            since_q <= since_q + 8'h01;
    end
    sequence s_launch;
        frame_start ##1 (frame_active && !frame_start);
    endsequence
    property p_arm_first; frame_start |-> armed_q || $past(armed_q); endproperty
    a_arm_first: assert property (p_arm_first) else $error("frame without arm");
    property p_setup_gap; frame_start |-> since_q >= SETUP_CNT; endproperty
    a_setup_gap: assert property (p_setup_gap) else $error("frame inside setup");
    property p_launch; frame_start |-> s_launch; endproperty
    a_launch: assert property (p_launch) else $error("frame start without active");
    // the launch cycle shows start and active together; a second start inside a running frame is an overlap
    property p_no_overlap; frame_active && $past(frame_active) |-> !frame_start; endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("overlapped frame");
    property p_hold; frame_active && !frame_done |=> frame_active; endproperty
    a_hold: assert property (p_hold) else $error("frame cut short");
    property p_end; frame_active && frame_done |=> !frame_active; endproperty
    a_end: assert property (p_end) else $error("frame not ended");
    property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait state not one");
    property p_unmapped; avs_read && !avs_waitrequest && avs_address == 5'h1c |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : aat_acq_checker

bind aat_acq_ctrl aat_acq_checker #(.SETUP_CNT(SETUP_CNT), .LINES(LINES)) u_chk (.clock(clock),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trig_line(trig_line), .frame_start(frame_start),
    .frame_active(frame_active), .frame_done(frame_done));

// ---- verification/aat_trig_src.sv ----
// external trigger lines and frame path model
`timescale 1ns/1ps
module aat_trig_src
    import aat_pkg::*;
(
    // clock
    input wire logic clock,
    // frame path
    input wire logic frame_start,
    output logic frame_done,
    // trigger lines
    output logic [LINE_COUNT-1:0] trig_line
);
    int done_dly = 6;
    int n_frames = 0;
    initial begin
        frame_done = 1'b0;
        trig_line = '0;
    end
    // count launches, end each frame after done_dly cycles
    always @(posedge clock) begin
        if (frame_start === 1'b1) begin
            n_frames++;
            repeat (done_dly) @(posedge clock);
            frame_done <= 1'b1;
            @(posedge clock);
            frame_done <= 1'b0;
        end
    end
    task automatic set_line(input int idx, input logic lvl);
        @(posedge clock);
        trig_line[idx] <= lvl;
        repeat (8) @(posedge clock);
    endtask : set_line
endmodule : aat_trig_src

// ---- verification/tb.sv ----
// self-checking bench for the acquisition control
`timescale 1ns/1ps
module tb
    import aat_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = '0;
    logic [3:0] be = 4'h1;
    logic [31:0] rdat;
    logic wait_r;
    logic [1:0] lines;
    logic fs;
    logic fa;
    logic fd;
    int n_errors = 0;
    int check_count = 0;
    int n0;
    always #2 clock = ~clock;
    aat_acq_ctrl DUT (.clock(clock), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_r),
        .trig_line(lines), .frame_start(fs), .frame_active(fa), .frame_done(fd));
    aat_trig_src u_src (.clock(clock), .frame_start(fs), .frame_done(fd), .trig_line(lines));
    // ==========================================================
    // bus and compare tasks
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        do
            @(posedge clock);
        while (wait_r !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic wreg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, exp, q & m);
    endtask : rchk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic frames(input int exp);
        chk("frames", 32'(exp), 32'(u_src.n_frames - n0));
    endtask : frames
    // ==========================================================
    // scenarios
    task automatic t_reset();
        rchk("ctrl", REG_CTRL, 32'hffffffff, 32'h0);
        rchk("burst len", REG_BURST_LEN, 32'hffffffff, 32'h1);
        rchk("unmapped", 5'h1c, 32'hffffffff, 32'h0);
        rchk("cmd", REG_CMD, 32'hffffffff, 32'h0);
        cyc(20);
        rchk("state", REG_STATUS, 32'h7, 32'h0);
        chk("no frame", 32'h0, 32'(u_src.n_frames));
    endtask : t_reset
    task automatic t_single();
        n0 = u_src.n_frames;
        wreg(REG_CMD, 32'h1);
        cyc(60);
        frames(1);
        rchk("state", REG_STATUS, 32'h7, 32'h0);
        rchk("frame cnt", REG_FRAME_CNT, 32'hffff, 32'h1);
    endtask : t_single
    task automatic t_cont();
        int n1;
        n0 = u_src.n_frames;
        wreg(REG_CTRL, 32'h1);
        wreg(REG_CMD, 32'h1);
        cyc(80);
        chk("cont frames", 32'h1, 32'(u_src.n_frames - n0 >= 4));
        while (fa !== 1'b1)
            @(posedge clock);
        wreg(REG_CMD, 32'h2);
        cyc(30);
        n1 = u_src.n_frames;
        rchk("state", REG_STATUS, 32'h7, 32'h0);
        cyc(30);
        chk("stopped", 32'(n1), 32'(u_src.n_frames));
    endtask : t_cont
    task automatic t_burst_sw();
        wreg(REG_CTRL, 32'h3);
        wreg(REG_TRIG_CFG, 32'h1);
        wreg(REG_BURST_LEN, 32'h3);
        wreg(REG_BURST_LEN, 32'h0);
        rchk("burst len", REG_BURST_LEN, 32'hff, 32'h3);
        rchk("arm cfg", REG_TRIG_CFG, 32'hf, 32'h1);
        n0 = u_src.n_frames;
        wreg(REG_CMD, 32'h1);
        cyc(40);
        rchk("state", REG_STATUS, 32'h7, 32'h2);
        frames(0);
        for (int i = 1; i <= 2; i++) begin
            wreg(REG_CMD, 32'h4);
            cyc(60);
            frames(3 * i);
            rchk("state", REG_STATUS, 32'h7, 32'h2);
        end
    endtask : t_burst_sw
    task automatic t_burst_line();
        wreg(REG_CMD, 32'h2);
        rchk("state", REG_STATUS, 32'h7, 32'h0);
        wreg(REG_TRIG_CFG, 32'hd);
        n0 = u_src.n_frames;
        wreg(REG_CMD, 32'h1);
        cyc(30);
        u_src.set_line(0, 1'b1);
        u_src.set_line(0, 1'b0);
        frames(0);
        u_src.set_line(1, 1'b1);
        frames(0);
        u_src.set_line(1, 1'b0);
        cyc(60);
        frames(3);
    endtask : t_burst_line
    task automatic t_single_burst();
        wreg(REG_CMD, 32'h2);
        wreg(REG_CTRL, 32'h2);
        wreg(REG_TRIG_CFG, 32'h1);
        n0 = u_src.n_frames;
        wreg(REG_CMD, 32'h1);
        cyc(30);
        wreg(REG_CMD, 32'h4);
        cyc(60);
        frames(1);
        rchk("state", REG_STATUS, 32'h7, 32'h0);
    endtask : t_single_burst
    task automatic t_frame_trig();
        be <= 4'h0;
        wreg(REG_BURST_LEN, 32'h5);
        be <= 4'h1;
        rchk("lane off", REG_BURST_LEN, 32'hff, 32'h3);
        wreg(REG_CTRL, 32'h1);
        wreg(REG_TRIG_CFG, 32'h3);
        rchk("fs cfg", REG_TRIG_CFG, 32'hf, 32'h3);
        n0 = u_src.n_frames;
        wreg(REG_CMD, 32'h1);
        cyc(30);
        u_src.set_line(0, 1'b1);
        u_src.set_line(0, 1'b0);
        frames(0);
        rchk("dropped", REG_DROP_CNT, 32'hffff, 32'h1);
        wreg(REG_CTRL, 32'h3);
        wreg(REG_CMD, 32'h4);
        wreg(REG_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            u_src.set_line(0, 1'b1);
            u_src.set_line(0, 1'b0);
        end
        frames(3);
        rchk("dropped", REG_DROP_CNT, 32'hffff, 32'h2);
        rchk("state", REG_STATUS, 32'h7, 32'h2);
    endtask : t_frame_trig
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_single();
        t_cont();
        t_burst_sw();
        t_burst_line();
        t_single_burst();
        t_frame_trig();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        stop_test();
    end
endmodule : tb

// ---- verilog/aat_acq_ctrl.sv ----
// acquisition arm, burst-arming trigger and frame start gating with avalon-mm registers
//
// Function
// - no frame before an arm command
// - idle disarm stops acquisition at once
// - disarm mid-frame waits for frame end
// - run style: single frame or continuous
// - single style: one frame, then self-disarm
// - continuous: each trigger yields one frame
// - SETUP_CNT setup cycles per arm, no overlap
// - burst arming off: generated internally
// - burst arming on: wait, drop frame triggers
// - arming trigger opens frame trigger wait
// - burst count reached: back to arm wait
// - burst counting only while arming enabled
// - arming origin: software, line one, two
// - software command is one arming trigger
// - only the selected line arms
// - edge polarity picks rising or falling
// - single style ignores frames-per-burst
// - frames-per-burst accepts 1 to 255
// - frame trigger ignored outside frame wait
// - settings follow the trigger target selector
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps

module aat_acq_ctrl
    import aat_pkg::*;
#(
    parameter int SETUP_CNT = SETUP_CYCLES,
    parameter int LINES = LINE_COUNT
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // hardware trigger input lines
    input wire logic [LINES-1:0] trig_line,
    // frame path
    output logic frame_start,
    output logic frame_active,
    input wire logic frame_done
);

    // ==========================================================
    // elaboration checks
    if (SETUP_CNT < 1 || SETUP_CNT > 255) begin : g_bad_setup
        $error("setup count must be 1 to 255");
    end
    if (LINES != 2) begin : g_bad_lines
        $error("exactly two trigger lines are served");
    end

    // ==========================================================
    // declarations
    aat_state_t state_q;
    logic cont_q;
    logic sel_arm_q;
    aat_trig_cfg_t arm_cfg_q;
    aat_trig_cfg_t fs_cfg_q;
    logic [7:0] burst_len_q;
    logic [7:0] burst_cnt_q;
    logic [7:0] setup_cnt_q;
    logic pend_q;
    logic [15:0] drop_cnt_q;
    logic [15:0] frame_cnt_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic frame_start_q;
    logic [LINES-1:0] sync1_q;
    logic [LINES-1:0] sync2_q;
    logic [LINES-1:0] prev_q;
    logic [LINES-1:0] rise;
    logic [LINES-1:0] fall;
    logic req;
    logic wr_en;
    logic cmd_arm;
    logic cmd_disarm;
    logic cmd_sw;
    logic arm_evt;
    logic fs_evt;
    logic [31:0] rd_mux;

    // ==========================================================
    // trigger line synchronisers and edge detection
    for (genvar i = 0; i < LINES; i++) begin : g_line
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
                prev_q[i] <= 1'b0;
            end else begin
                sync1_q[i] <= trig_line[i];
                sync2_q[i] <= sync1_q[i];
                prev_q[i] <= sync2_q[i];
            end
        end
        assign rise[i] = sync2_q[i] & ~prev_q[i];
        assign fall[i] = ~sync2_q[i] & prev_q[i];
    end

    // ==========================================================
    // trigger event selection
    function automatic logic trig_event(aat_trig_cfg_t cfg, logic sw_cmd, logic [1:0] r, logic [1:0] f);
        logic hit;
        hit = 1'b0;
        unique case (cfg.origin)
            AAT_ORG_SW: hit = sw_cmd;
            AAT_ORG_LINE1: hit = cfg.falling ? f[0] : r[0];
            AAT_ORG_LINE2: hit = cfg.falling ? f[1] : r[1];
            AAT_ORG_NONE: hit = 1'b0;
        endcase
        return hit;
    endfunction : trig_event

    // software trigger reaches only the selected target
    assign arm_evt = arm_cfg_q.enable ? trig_event(arm_cfg_q, cmd_sw & sel_arm_q, rise, fall) : 1'b1;
    assign fs_evt = fs_cfg_q.enable ? trig_event(fs_cfg_q, cmd_sw & ~sel_arm_q, rise, fall) : 1'b1;

    // ==========================================================
    // avalon-mm handshake: answer on the second edge of a request
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_en = avs_write & ack_q;
    assign cmd_arm = wr_en && avs_address == REG_CMD && avs_byteenable[0] && avs_writedata[CMD_ARM_BIT];
    assign cmd_disarm = wr_en && avs_address == REG_CMD && avs_byteenable[0] && avs_writedata[CMD_DISARM_BIT];
    assign cmd_sw = wr_en && avs_address == REG_CMD && avs_byteenable[0] && avs_writedata[CMD_SWTRIG_BIT];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            REG_CTRL: begin
                rd_mux[CTRL_CONT_BIT] = cont_q;
                rd_mux[CTRL_SEL_BIT] = sel_arm_q;
            end
            REG_TRIG_CFG: rd_mux[CFG_FALL_BIT:CFG_EN_BIT] = sel_arm_q ? arm_cfg_q : fs_cfg_q;
            REG_BURST_LEN: rd_mux[7:0] = burst_len_q;
            REG_STATUS: begin
                rd_mux[STAT_STATE_LSB +: 3] = state_q;
                rd_mux[STAT_PEND_BIT] = pend_q;
                rd_mux[STAT_CNT_LSB +: 8] = burst_cnt_q;
            end
            REG_DROP_CNT: rd_mux[15:0] = drop_cnt_q;
            REG_FRAME_CNT: rd_mux[15:0] = frame_cnt_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            rdata_q <= rd_mux;
        end
    end
    assign avs_readdata = rdata_q;

    // ==========================================================
    // configuration registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cont_q <= 1'b0;
            sel_arm_q <= 1'b0;
        end else if (wr_en && avs_address == REG_CTRL && avs_byteenable[0]) begin
            cont_q <= avs_writedata[CTRL_CONT_BIT];
            sel_arm_q <= avs_writedata[CTRL_SEL_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arm_cfg_q <= TRIG_CFG_RST;
            fs_cfg_q <= TRIG_CFG_RST;
        end else if (wr_en && avs_address == REG_TRIG_CFG && avs_byteenable[0]) begin
            if (sel_arm_q) begin
                arm_cfg_q <= aat_trig_cfg_t'(avs_writedata[CFG_FALL_BIT:CFG_EN_BIT]);
            end else begin
                fs_cfg_q <= aat_trig_cfg_t'(avs_writedata[CFG_FALL_BIT:CFG_EN_BIT]);
            end
        end
    end

    // out-of-range lengths are dropped, the old value stays
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            burst_len_q <= BURST_LEN_RST;
        end else if (wr_en && avs_address == REG_BURST_LEN && avs_byteenable[0]) begin
            if (avs_writedata[7:0] >= BURST_LEN_MIN && avs_writedata[7:0] <= BURST_LEN_MAX) begin
                burst_len_q <= avs_writedata[7:0];
            end
        end
    end

    // ==========================================================
    // acquisition state machine
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= AAT_ST_IDLE;
        end else begin
            unique case (state_q)
                AAT_ST_IDLE: begin
                    if (cmd_arm) begin
                        state_q <= AAT_ST_SETUP;
                    end
                end
                AAT_ST_SETUP: begin
                    if (cmd_disarm) begin
                        state_q <= AAT_ST_IDLE;
                    end else if (setup_cnt_q == 8'(SETUP_CNT - 1)) begin
                        state_q <= arm_cfg_q.enable ? AAT_ST_WAIT_ARM : AAT_ST_WAIT_FRAME;
                    end
                end
                AAT_ST_WAIT_ARM: begin
                    if (cmd_disarm) begin
                        state_q <= AAT_ST_IDLE;
                    end else if (arm_evt) begin
                        state_q <= AAT_ST_WAIT_FRAME;
                    end
                end
                AAT_ST_WAIT_FRAME: begin
                    if (cmd_disarm) begin
                        state_q <= AAT_ST_IDLE;
                    end else if (fs_evt) begin
                        state_q <= AAT_ST_ACQ;
                    end
                end
                AAT_ST_ACQ: begin
                    if (frame_done) begin
                        if (!cont_q || pend_q || cmd_disarm) begin
                            state_q <= AAT_ST_IDLE;
                        end else if (arm_cfg_q.enable && burst_cnt_q == burst_len_q) begin
                            state_q <= AAT_ST_WAIT_ARM;
                        end else begin
                            state_q <= AAT_ST_WAIT_FRAME;
                        end
                    end
                end
                default: state_q <= AAT_ST_IDLE;
            endcase
        end
    end

    // setup cycle counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            setup_cnt_q <= 8'h00;
        end else if (state_q == AAT_ST_SETUP) begin
            setup_cnt_q <= setup_cnt_q + 8'h01;
        end else begin
            setup_cnt_q <= 8'h00;
        end
    end

    // disarm held until the running frame ends
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else if (state_q != AAT_ST_ACQ) begin
            pend_q <= 1'b0;
        end else if (cmd_disarm) begin
            pend_q <= 1'b1;
        end
    end

    // frame start triggers counted since the last arming trigger
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            burst_cnt_q <= 8'h00;
        end else if (state_q == AAT_ST_IDLE) begin
            burst_cnt_q <= 8'h00;
        end else if (state_q == AAT_ST_WAIT_ARM && arm_evt && !cmd_disarm) begin
            burst_cnt_q <= 8'h00;
        end else if (state_q == AAT_ST_WAIT_FRAME && fs_evt && !cmd_disarm && arm_cfg_q.enable) begin
            burst_cnt_q <= burst_cnt_q + 8'h01;
        end
    end

    // enabled frame triggers, from a line or software, refused outside the frame wait
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drop_cnt_q <= 16'h0000;
        end else if (fs_cfg_q.enable && fs_evt && state_q != AAT_ST_WAIT_FRAME) begin
            drop_cnt_q <= drop_cnt_q + 16'h0001;
        end
    end

    // ==========================================================
    // frame path outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_start_q <= 1'b0;
        end else begin
            frame_start_q <= state_q == AAT_ST_WAIT_FRAME && fs_evt && !cmd_disarm;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_cnt_q <= 16'h0000;
        end else if (frame_start_q) begin
            frame_cnt_q <= frame_cnt_q + 16'h0001;
        end
    end

    assign frame_start = frame_start_q;
    assign frame_active = state_q == AAT_ST_ACQ;

endmodule : aat_acq_ctrl
